/* src/ctio_pkg.sv */
// Package for the tail-instruction execution block: opcodes, widths, reset values.
// Assumes a single 40 MHz system clock; the decoder upstream presents one op at a time and holds it until ready_o.
// Behaviour
// - Nibble exchange: operand high nibble to working low, low to high; no flags.
// - Skip-on-null tests whole byte; skip next instruction if zero; flags untouched.
// - A taken skip inserts one dummy cycle, two instruction cycles in total.
// - Skip-on-null-with-copy copies byte to working register, skips if zero.
// - Bit-test skip: skip if selected bit is zero; flags untouched.
// - Current-page table read: low byte to memory, high byte to latch.
// - Final-page table read: same, from the last program page.
// - Exclusive-OR into working register; only null-result flag changes.
// - Exclusive-OR into memory byte; only null-result flag changes.
// - Exclusive-OR of working register with immediate; only null flag changes.
package ctio_pkg;
	localparam int DATA_W = 8;
	localparam int PROG_W = 16;
	localparam int PC_W   = 13;
	localparam int TP_W   = 8;
	localparam int BIT_W  = 3;
	localparam int OP_W   = 4;

	localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
	localparam logic [PC_W-TP_W-1:0] LAST_PAGE = 5'h1F;

	typedef enum logic [OP_W-1:0] {
		CTIO_OP_NOP       = 4'h0,
		CTIO_OP_SWAPW     = 4'h1,
		CTIO_OP_SKNULL    = 4'h2,
		CTIO_OP_SKNULLCP  = 4'h3,
		CTIO_OP_SKBIT     = 4'h4,
		CTIO_OP_TRDCUR    = 4'h5,
		CTIO_OP_TRDFIN    = 4'h6,
		CTIO_OP_XORW      = 4'h7,
		CTIO_OP_XOR_MEM   = 4'h8,
		CTIO_OP_XORI      = 4'h9
	} ctio_op_t;

	typedef enum logic [1:0] {
		CTIO_ST_EXEC  = 2'b00,
		CTIO_ST_DUMMY = 2'b01,
		CTIO_ST_TWAIT = 2'b10
	} ctio_state_t;
endpackage

/* src/ctio_alu_if.sv */
// Interface between the sequencer and the operand ALU.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface ctio_alu_if;
	import ctio_pkg::*;
	ctio_op_t          op;
	logic [DATA_W-1:0] work;
	logic [DATA_W-1:0] mem;
	logic [DATA_W-1:0] imm;
	logic [BIT_W-1:0]  bsel;
	logic [DATA_W-1:0] result;
	logic              wr_work;
	logic              wr_mem;
	logic              null_upd;
	logic              null_val;
	logic              skip;
	modport seq (output op, work, mem, imm, bsel,
		input result, wr_work, wr_mem, null_upd, null_val, skip);
	modport alu (input op, work, mem, imm, bsel,
		output result, wr_work, wr_mem, null_upd, null_val, skip);
endinterface

/* src/ctio_alu.sv */
// Combinational operand unit for the tail instructions.
// Assumes operands are stable for the cycle in which the op is presented.
`timescale 1ns/1ps
module ctio_alu
(
	ctio_alu_if.alu a   // Operands in, result and effects out
);
	import ctio_pkg::*;

	always_comb
	begin
		a.result   = '0;
		a.wr_work  = 1'b0;
		a.wr_mem   = 1'b0;
		a.null_upd = 1'b0;
		a.skip     = 1'b0;
		unique case (a.op)
			CTIO_OP_SWAPW:
			begin
				a.result  = {a.mem[3:0], a.mem[7:4]};
				a.wr_work = 1'b1;
			end
			CTIO_OP_SKNULL:
				a.skip = (a.mem == '0);
			CTIO_OP_SKNULLCP:
			begin
				a.result  = a.mem;
				a.wr_work = 1'b1;
				a.skip    = (a.mem == '0);
			end
			CTIO_OP_SKBIT:
				a.skip = ~a.mem[a.bsel];
			CTIO_OP_XORW:
			begin
				a.result   = a.work ^ a.mem;
				a.wr_work  = 1'b1;
				a.null_upd = 1'b1;
			end
			CTIO_OP_XOR_MEM:
			begin
				a.result   = a.mem ^ a.work;
				a.wr_mem   = 1'b1;
				a.null_upd = 1'b1;
			end
			CTIO_OP_XORI:
			begin
				a.result   = a.work ^ a.imm;
				a.wr_work  = 1'b1;
				a.null_upd = 1'b1;
			end
			default:
				a.result = '0;
		endcase
		a.null_val = (a.result == '0);
	end
endmodule

/* src/ctio_core.sv */
// Execution sequencer for the tail instruction group of an 8-bit core.
// Assumes the decoder holds op_i and operands until ready_o, and that the
// program memory answers a read request on the next clock edge.
`timescale 1ns/1ps
module ctio_core
(
	input  wire logic                     clk_sys_i,     // 40 MHz system clock
	input  wire logic                     rst_i,         // Async reset, active high
	input  wire logic                     valid_i,       // Op presented this cycle
	input  wire ctio_pkg::ctio_op_t       op_i,          // Decoded instruction
	input  wire logic [ctio_pkg::DATA_W-1:0] mem_i,      // Addressed data byte
	input  wire logic [ctio_pkg::DATA_W-1:0] imm_i,      // Immediate constant
	input  wire logic [ctio_pkg::BIT_W-1:0]  bsel_i,     // Bit position
	input  wire logic [ctio_pkg::PC_W-1:0]   pc_i,       // Executing instruction address
	input  wire logic [ctio_pkg::TP_W-1:0]   tptr_i,     // Table pointer
	input  wire logic [ctio_pkg::PROG_W-1:0] prog_data_i, // Program word read back
	output logic                          ready_o,       // Op finished this cycle
	output logic                          dummy_o,       // Dummy cycle in progress
	output logic                          skip_next_o,   // Next fetch is discarded
	output logic [ctio_pkg::DATA_W-1:0]   working_register_o, // Working register
	output logic                          null_flag_o,   // Null-result flag
	output logic [ctio_pkg::DATA_W-1:0]   table_high_byte_latch_o, // Table high byte
	output logic                          mem_we_o,      // Data byte write strobe
	output logic [ctio_pkg::DATA_W-1:0]   mem_wdata_o,   // Data byte write value
	output logic                          prog_re_o,     // Program read request
	output logic [ctio_pkg::PC_W-1:0]     prog_addr_o    // Program read address
);
	import ctio_pkg::*;

	ctio_alu_if alu_bus ();

	// Sequencer state and the pulses it raises
	ctio_state_t       st_q, st_d;
	logic              rdy_q, rdy_d;
	logic              skp_q, skp_d;
	logic              dum_q, dum_d;
	// Working register and null-result flag
	logic [DATA_W-1:0] work_q, work_d;
	logic              null_q, null_d;
	// Data byte write port
	logic              we_q, we_d;
	logic [DATA_W-1:0] wdat_q, wdat_d;
	// Program read port and table high-byte latch
	logic              pre_q, pre_d;
	logic [PC_W-1:0]   padr_q, padr_d;
	logic [DATA_W-1:0] thb_q, thb_d;
	// Issue strobes for the ALU and table groups, and table completion
	logic              take_alu;
	logic              take_tbl;
	logic              tbl_done;

	function automatic logic is_table_read(input ctio_op_t op);
		return (op == CTIO_OP_TRDCUR) || (op == CTIO_OP_TRDFIN);
	endfunction

	function automatic logic [PC_W-1:0] table_addr
	(
		input ctio_op_t        op,
		input logic [PC_W-1:0] pc,
		input logic [TP_W-1:0] tp
	);
		// Page bits come from the executing address or from the final page
		if (op == CTIO_OP_TRDFIN)
			return {LAST_PAGE, tp};
		else
			return {pc[PC_W-1:TP_W], tp};
	endfunction

	// Ops are only accepted while idle, so a busy sequencer ignores valid_i
	assign take_alu = valid_i && (st_q == CTIO_ST_EXEC) && !is_table_read(op_i);
	assign take_tbl = valid_i && (st_q == CTIO_ST_EXEC) && is_table_read(op_i);
	assign tbl_done = (st_q == CTIO_ST_TWAIT);

	assign alu_bus.op   = take_alu ? op_i : CTIO_OP_NOP;
	assign alu_bus.work = work_q;
	assign alu_bus.mem  = mem_i;
	assign alu_bus.imm  = imm_i;
	assign alu_bus.bsel = bsel_i;

	ctio_alu u_alu
	(
		.a (alu_bus.alu)
	);

	always_comb
	begin
		st_d  = st_q;
		rdy_d = 1'b0;
		skp_d = 1'b0;
		dum_d = 1'b0;
		unique case (st_q)
			CTIO_ST_EXEC:
			begin
				if (take_tbl)
					st_d = CTIO_ST_TWAIT;
				else if (take_alu && alu_bus.skip)
				begin
					// Dummy cycle covers the discarded fetch
					skp_d = 1'b1;
					dum_d = 1'b1;
					st_d  = CTIO_ST_DUMMY;
				end
				else if (take_alu)
					rdy_d = 1'b1;
			end
			CTIO_ST_DUMMY:
			begin
				rdy_d = 1'b1;
				st_d  = CTIO_ST_EXEC;
			end
			CTIO_ST_TWAIT:
			begin
				rdy_d = 1'b1;
				st_d  = CTIO_ST_EXEC;
			end
			default:
				st_d = CTIO_ST_EXEC;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_q  <= CTIO_ST_EXEC;
			rdy_q <= 1'b0;
			skp_q <= 1'b0;
			dum_q <= 1'b0;
		end
		else
		begin
			st_q  <= st_d;
			rdy_q <= rdy_d;
			skp_q <= skp_d;
			dum_q <= dum_d;
		end
	end

	always_comb
	begin
		work_d = work_q;
		null_d = null_q;
		if (take_alu && alu_bus.wr_work)
			work_d = alu_bus.result;
		// Only the exclusive-OR ops raise null_upd; skips and swaps leave the flag
		if (take_alu && alu_bus.null_upd)
			null_d = alu_bus.null_val;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			work_q <= WORK_RST;
			null_q <= 1'b0;
		end
		else
		begin
			work_q <= work_d;
			null_q <= null_d;
		end
	end

	always_comb
	begin
		we_d   = 1'b0;
		wdat_d = wdat_q;
		if (tbl_done)
		begin
			we_d   = 1'b1;
			wdat_d = prog_data_i[DATA_W-1:0];
		end
		else if (take_alu && alu_bus.wr_mem)
		begin
			we_d   = 1'b1;
			wdat_d = alu_bus.result;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			we_q   <= 1'b0;
			wdat_q <= '0;
		end
		else
		begin
			we_q   <= we_d;
			wdat_q <= wdat_d;
		end
	end

	always_comb
	begin
		pre_d  = 1'b0;
		padr_d = padr_q;
		thb_d  = thb_q;
		if (take_tbl)
		begin
			pre_d  = 1'b1;
			padr_d = table_addr(op_i, pc_i, tptr_i);
		end
		// Flags stay untouched on table reads
		if (tbl_done)
			thb_d = prog_data_i[PROG_W-1:DATA_W];
	end

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pre_q  <= 1'b0;
			padr_q <= '0;
			thb_q  <= '0;
		end
		else
		begin
			pre_q  <= pre_d;
			padr_q <= padr_d;
			thb_q  <= thb_d;
		end
	end

	assign ready_o                 = rdy_q;
	assign dummy_o                 = dum_q;
	assign skip_next_o             = skp_q;
	assign working_register_o      = work_q;
	assign null_flag_o             = null_q;
	assign table_high_byte_latch_o = thb_q;
	assign mem_we_o                = we_q;
	assign mem_wdata_o             = wdat_q;
	assign prog_re_o               = pre_q;
	assign prog_addr_o             = padr_q;
endmodule

/* sim/ctio_core_assertions.sv */
// Checker for the tail-instruction block, bound to ctio_core.
// Assumes the driver holds op and operands until ready_o.
`timescale 1ns/1ps
module ctio_core_assertions
(
	input wire logic              clk_sys_i,          // Clock
	input wire logic              rst_i,              // Reset
	input wire ctio_pkg::ctio_op_t op_i,              // Op
	input wire logic [7:0]        mem_i,              // Data byte
	input wire logic [2:0]        bsel_i,             // Bit index
	input wire logic [7:0]        imm_i,              // Immediate
	input wire logic [12:0]       pc_i,               // Address
	input wire logic [7:0]        tptr_i,             // Pointer
	input wire logic              ready_o,            // Done
	input wire logic              dummy_o,            // Dummy
	input wire logic              skip_next_o,        // Skip
	input wire logic [7:0]        working_register_o, // Work
	input wire logic              null_flag_o,        // Null
	input wire logic              mem_we_o,           // Write
	input wire logic [7:0]        mem_wdata_o,        // Write data
	input wire logic              prog_re_o,          // Prog read
	input wire logic [12:0]       prog_addr_o         // Prog addr
);
	import ctio_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence s_dummy; dummy_o ##1 (ready_o && !dummy_o); endsequence
	sequence s_load; mem_we_o && ready_o; endsequence
	property p_swap; ready_o && op_i == CTIO_OP_SWAPW |->
		working_register_o == {mem_i[3:0], mem_i[7:4]} && !mem_we_o; endproperty
	a_swap: assert property (p_swap) else $error("nibble exchange wrong");
	// Skip flag is one cycle ahead of ready when taken, absent when not
	property p_skip; ready_o && op_i inside {CTIO_OP_SKNULL, CTIO_OP_SKNULLCP, CTIO_OP_SKBIT} |->
		$past(skip_next_o) == (op_i == CTIO_OP_SKBIT ? !mem_i[bsel_i] : mem_i == 8'h00);
	endproperty
	a_skip: assert property (p_skip) else $error("skip decision wrong");
	property p_two; skip_next_o |-> s_dummy; endproperty
	a_two: assert property (p_two) else $error("taken skip not two cycles");
	property p_copy; ready_o && op_i == CTIO_OP_SKNULLCP |-> working_register_o == mem_i;
	endproperty
	a_copy: assert property (p_copy) else $error("copy to work wrong");
	property p_tbl; prog_re_o |-> prog_addr_o ==
		{(op_i == CTIO_OP_TRDFIN) ? LAST_PAGE : pc_i[12:8], tptr_i} ##1 s_load; endproperty
	a_tbl: assert property (p_tbl) else $error("table read wrong");
	property p_xorw; ready_o && op_i == CTIO_OP_XORW |-> working_register_o ==
		($past(working_register_o) ^ mem_i) && null_flag_o == (working_register_o == 8'h00);
	endproperty
	a_xorw: assert property (p_xorw) else $error("xor to work wrong");
	property p_xor_mem; mem_we_o && op_i == CTIO_OP_XOR_MEM |-> mem_wdata_o ==
		(working_register_o ^ mem_i) && null_flag_o == (mem_wdata_o == 8'h00); endproperty
	a_xor_mem: assert property (p_xor_mem) else $error("xor to memory wrong");
	property p_xori; ready_o && op_i == CTIO_OP_XORI |-> working_register_o ==
		($past(working_register_o) ^ imm_i) && null_flag_o == (working_register_o == 8'h00);
	endproperty
	a_xori: assert property (p_xori) else $error("xor with immediate wrong");
	property p_flag; ready_o && op_i inside {[CTIO_OP_SWAPW:CTIO_OP_TRDFIN]} |->
		$stable(null_flag_o); endproperty
	a_flag: assert property (p_flag) else $error("null flag moved");
endmodule
bind ctio_core ctio_core_assertions u_chk (.clk_sys_i, .rst_i, .op_i, .mem_i, .bsel_i, .imm_i,
	.pc_i, .tptr_i, .ready_o, .dummy_o, .skip_next_o, .working_register_o, .null_flag_o,
	.mem_we_o, .mem_wdata_o, .prog_re_o, .prog_addr_o);

/* sim/testbench.sv */
// Self-checking bench for ctio_core.
// Assumes program data is held steady across each table read.
`timescale 1ns/1ps
module testbench;
	import ctio_pkg::*;
	logic clk_sys_i = 0, rst_i = 1, valid_i = 0, ready_o, dummy_o, skip_next_o, null_flag_o;
	logic mem_we_o, prog_re_o, skp, dm;
	ctio_op_t op_i = CTIO_OP_NOP;
	logic [7:0] mem_i = 8'h00, imm_i = 8'h00, tptr_i = 8'h00;
	logic [7:0] working_register_o, table_high_byte_latch_o, mem_wdata_o;
	logic [2:0] bsel_i = 3'h0;
	logic [12:0] pc_i = 13'h0000, prog_addr_o, pa;
	logic [15:0] prog_data_i = 16'h0000;
	logic [8:0] wd;
	int cyc, miscompares = 0, n_tests = 0;
	ctio_core u_dut (.clk_sys_i, .rst_i, .valid_i, .op_i, .mem_i, .imm_i, .bsel_i, .pc_i,
		.tptr_i, .prog_data_i, .ready_o, .dummy_o, .skip_next_o, .working_register_o,
		.null_flag_o, .table_high_byte_latch_o, .mem_we_o, .mem_wdata_o, .prog_re_o,
		.prog_addr_o);
	initial forever #12.5 clk_sys_i = ~clk_sys_i;
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// Holds the request until ready, bounded so a silent design cannot hang here
	task run(input ctio_op_t o, input logic [7:0] m, input logic [7:0] k, input logic [2:0] b);
		@(negedge clk_sys_i);
		valid_i = 1; op_i = o; mem_i = m; imm_i = k; bsel_i = b; cyc = 0; skp = 0;
		dm = 0;
		do
		begin
			@(posedge clk_sys_i);
			#1;
			cyc++;
			skp |= skip_next_o;
			dm |= dummy_o;
			if (prog_re_o) pa = prog_addr_o;
		end while (ready_o !== 1'b1 && cyc < 9);
		wd = {mem_we_o, mem_wdata_o};
		@(negedge clk_sys_i);
		valid_i = 0;
	endtask
	task t_swap_xor;
		run(CTIO_OP_SWAPW, 8'h3C, 8'h00, 3'h0);
		chk(working_register_o, 8'hC3);
		chk({cyc[7:0], 7'h0, wd[8]}, 16'h0100);
		run(CTIO_OP_XORI, 8'h00, 8'hC3, 3'h0);
		chk({working_register_o, 7'h0, null_flag_o}, 16'h0001);
		run(CTIO_OP_XORW, 8'hA5, 8'h00, 3'h0);
		chk({working_register_o, 7'h0, null_flag_o}, 16'hA500);
		run(CTIO_OP_XOR_MEM, 8'hA5, 8'h00, 3'h0);
		chk({working_register_o, 7'h0, null_flag_o}, 16'hA501);
		chk(wd, 9'h100);
	endtask
	task t_skip;
		run(CTIO_OP_SKNULL, 8'h00, 8'h00, 3'h0);
		chk({cyc[7:0], 7'h0, skp}, 16'h0201);
		chk(dm, 1'b1);
		run(CTIO_OP_SKNULL, 8'h01, 8'h00, 3'h0);
		chk({cyc[7:0], 7'h0, skp}, 16'h0100);
		chk(dm, 1'b0);
		run(CTIO_OP_SKNULLCP, 8'h00, 8'h00, 3'h0);
		chk({working_register_o, cyc[7:0]}, 16'h0002);
		run(CTIO_OP_SKNULLCP, 8'h5A, 8'h00, 3'h0);
		chk({working_register_o, cyc[7:0]}, 16'h5A01);
		for (int b = 0; b < 8; b++)
		begin
			run(CTIO_OP_SKBIT, 8'hFE, 8'h00, b[2:0]);
			chk(skp, b == 0);
		end
		chk(null_flag_o, 1'b1);
	endtask
	task t_table;
		pc_i = 13'h1A37; tptr_i = 8'h5C; prog_data_i = 16'hBEEF;
		run(CTIO_OP_TRDCUR, 8'h00, 8'h00, 3'h0);
		chk(pa, 13'h1A5C);
		chk({table_high_byte_latch_o, wd[7:0]}, 16'hBEEF);
		chk({cyc[7:0], 7'h0, wd[8]}, 16'h0201);
		prog_data_i = 16'h1234;
		run(CTIO_OP_TRDFIN, 8'h00, 8'h00, 3'h0);
		chk(pa, {LAST_PAGE, 8'h5C});
		chk({table_high_byte_latch_o, wd[7:0]}, 16'h1234);
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		#(25 * 2000);
		miscompares++;
		finish_test;
	end
	initial
	begin
		repeat (2) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		rst_i = 0;
		t_swap_xor;
		$display("swap and xor test done");
		t_skip;
		$display("skip test done");
		t_table;
		$display("table test done");
		finish_test;
	end
endmodule
